// >>> rtl/ssr_regs.svh
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH

// register selectors on the command port
`define SSR_SEL_QUES    3'h0
`define SSR_SEL_OPER    3'h1
`define SSR_SEL_ESR     3'h2
`define SSR_SEL_SRE     3'h3
`define SSR_SEL_STB     3'h4

// part selectors within a status register
`define SSR_PART_COND   3'h0
`define SSR_PART_PTR    3'h1
`define SSR_PART_NTR    3'h2
`define SSR_PART_EVT    3'h3
`define SSR_PART_ENA    3'h4

// bit 15 of every part is held at zero
`define SSR_PART_MASK   16'h7fff

// reset values
`define SSR_PTR_RST     16'h7fff
`define SSR_NTR_RST     16'h0000
`define SSR_EVT_RST     16'h0000
`define SSR_ENA_RST     16'h0000

// status byte bit positions
`define SSR_STB_ERRQ    2
`define SSR_STB_QUES    3
`define SSR_STB_MAV     4
`define SSR_STB_ESB     5
`define SSR_STB_MSS     6
`define SSR_STB_OPER    7
`define SSR_SRE_MASK    8'hbf

// operation-complete bit of the standard event status register
`define SSR_ESR_OPC     0

// response queued for the completion query
`define SSR_OPCQ_RESP   16'h0001

// error queue geometry
`define SSR_ERRQ_DEPTH  4'h8

`endif

// >>> rtl/ssr_pkg.sv
`default_nettype none
package ssr_pkg;

    typedef enum logic [2:0] {
        SSR_OP_READ  = 3'b000,
        SSR_OP_WRITE = 3'b001,
        SSR_OP_OPC   = 3'b010,
        SSR_OP_OPCQ  = 3'b011,
        SSR_OP_WAI   = 3'b100,
        SSR_OP_ERRQ  = 3'b101
    } ssr_op_t;

    typedef enum logic [1:0] {
        SSR_SY_IDLE = 2'b00,
        SSR_SY_WAI  = 2'b01,
        SSR_SY_OPCQ = 2'b10
    } ssr_sync_t;

    typedef struct packed {
        logic [15:0] cond;
        logic [15:0] ptr;
        logic [15:0] ntr;
        logic [15:0] evt;
        logic [15:0] ena;
    } ssr_scpi_t;

    typedef struct packed {
        ssr_op_t     op;
        logic [2:0]  sel;
        logic [2:0]  part;
        logic [15:0] wdata;
    } ssr_cmd_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } ssr_resp_t;

    typedef struct packed {
        ssr_scpi_t        ques;
        ssr_scpi_t        oper;
        logic [7:0]       esr;
        logic [7:0]       ese;
        logic [7:0]       sre;
        logic [7:0]       stb;
        logic [7:0][15:0] errq;
        logic [2:0]       wp;
        logic [2:0]       rp;
        logic [3:0]       cnt;
        logic             opc_armed;
        ssr_sync_t        sync;
        ssr_resp_t        rd;
        logic             srq;
        logic             oq_push;
    } ssr_state_t;

endpackage : ssr_pkg
`default_nettype wire

// >>> rtl/ssr_status.sv
// Overview of operation
// - QUES and OPER each have five 16-bit parts
// - bit 15 of every part reads zero
// - one source, same bit, all parts
// - condition follows hardware, read-only, never cleared
// - rising condition sets event if positive filter
// - falling condition sets event if negative filter
// - event latches filtered edges, read clears
// - summary is OR of event AND enable
// - error queue holds entries, read oldest first
// - output queue contents drive message-available bit
// - operation-complete sets bit 0 when done
// - completion query stalls, then queues response 1
// - wait command stalls until earlier commands finish
// - lower summary drives higher condition bit
// - enabled status byte rise raises service request
// - enabled event status sets summary bit
`timescale 1ns/1ns
`default_nettype none
`include "ssr_regs.svh"

module ssr_status (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire ssr_pkg::ssr_cmd_t cmd,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    output ssr_pkg::ssr_resp_t     rd,
    input  wire logic [14:0]       ques_cond_in,
    input  wire logic [14:0]       oper_cond_in,
    input  wire logic [7:0]        esr_set_in,
    input  wire logic              ops_pending,
    input  wire logic              err_push,
    input  wire logic [15:0]       err_code,
    input  wire logic              oq_not_empty,
    output logic                   oq_push,
    output logic [15:0]            oq_data,
    output logic [7:0]             status_byte,
    output logic                   srq
);

    ssr_pkg::ssr_state_t s_r;
    ssr_pkg::ssr_state_t s_nxt;

    // one step of a five-part status register
    function automatic ssr_pkg::ssr_scpi_t scpi_step(
        input ssr_pkg::ssr_scpi_t r,
        input logic [14:0]        cond_in,
        input logic               clr
    );
        ssr_pkg::ssr_scpi_t n;
        logic [15:0]        c;
        logic [15:0]        rise;
        logic [15:0]        fall;
        n    = r;
        c    = {1'b0, cond_in};
        rise = c & ~r.cond & r.ptr;
        fall = ~c & r.cond & r.ntr;
        n.cond = c;
        // set beats clear so an edge in the read cycle is kept
        n.evt = ((clr ? 16'h0000 : r.evt) | rise | fall)
                & `SSR_PART_MASK;
        return n;
    endfunction : scpi_step

    function automatic logic [15:0] scpi_read(
        input ssr_pkg::ssr_scpi_t r,
        input logic [2:0]         part
    );
        logic [15:0] v;
        case (part)
            `SSR_PART_COND: v = r.cond;
            `SSR_PART_PTR:  v = r.ptr;
            `SSR_PART_NTR:  v = r.ntr;
            `SSR_PART_EVT:  v = r.evt;
            `SSR_PART_ENA:  v = r.ena;
            default:        v = 16'h0000;
        endcase
        return v & `SSR_PART_MASK;
    endfunction : scpi_read

    function automatic ssr_pkg::ssr_scpi_t scpi_write(
        input ssr_pkg::ssr_scpi_t r,
        input logic [2:0]         part,
        input logic [15:0]        d
    );
        ssr_pkg::ssr_scpi_t n;
        n = r;
        case (part)
            `SSR_PART_PTR: n.ptr = d & `SSR_PART_MASK;
            `SSR_PART_NTR: n.ntr = d & `SSR_PART_MASK;
            `SSR_PART_ENA: n.ena = d & `SSR_PART_MASK;
            // condition and event parts ignore writes
            default:       n = r;
        endcase
        return n;
    endfunction : scpi_write

    logic             take;
    logic             is_rd;
    logic             is_wr;
    logic             ques_sum;
    logic             oper_sum;
    logic             esb;
    logic             clr_ques;
    logic             clr_oper;
    logic             clr_esr;
    logic             pop;
    logic             push;
    logic             opc_fire;
    logic [7:0]       stb_raw;
    logic [15:0]      rdata;

    assign cmd_ready   = (s_r.sync == ssr_pkg::SSR_SY_IDLE);
    assign rd          = s_r.rd;
    assign oq_push     = s_r.oq_push;
    assign oq_data     = `SSR_OPCQ_RESP;
    assign status_byte = s_r.stb;
    assign srq         = s_r.srq;

    always_comb begin
        s_nxt    = s_r;
        take     = cmd_valid && cmd_ready;
        is_rd    = take && (cmd.op == ssr_pkg::SSR_OP_READ);
        is_wr    = take && (cmd.op == ssr_pkg::SSR_OP_WRITE);
        clr_ques = is_rd && (cmd.sel == `SSR_SEL_QUES)
                   && (cmd.part == `SSR_PART_EVT);
        clr_oper = is_rd && (cmd.sel == `SSR_SEL_OPER)
                   && (cmd.part == `SSR_PART_EVT);
        clr_esr  = is_rd && (cmd.sel == `SSR_SEL_ESR)
                   && (cmd.part == `SSR_PART_EVT);
        pop      = take && (cmd.op == ssr_pkg::SSR_OP_ERRQ)
                   && (s_r.cnt != 4'h0);
        push     = err_push && (s_r.cnt != `SSR_ERRQ_DEPTH);

        // summaries climb the hierarchy into the status byte
        ques_sum = |(s_r.ques.evt & s_r.ques.ena);
        oper_sum = |(s_r.oper.evt & s_r.oper.ena);
        esb      = |(s_r.esr & s_r.ese);
        stb_raw  = 8'h00;
        stb_raw[`SSR_STB_ERRQ] = (s_r.cnt != 4'h0);
        stb_raw[`SSR_STB_QUES] = ques_sum;
        stb_raw[`SSR_STB_MAV]  = oq_not_empty;
        stb_raw[`SSR_STB_ESB]  = esb;
        stb_raw[`SSR_STB_OPER] = oper_sum;
        stb_raw[`SSR_STB_MSS]  = |(stb_raw & s_r.sre & `SSR_SRE_MASK);
        s_nxt.stb = stb_raw;
        // request on a 0-to-1 of an enabled bit; bit 6 never counts
        s_nxt.srq = |(stb_raw & ~s_r.stb & s_r.sre
                      & `SSR_SRE_MASK);

        s_nxt.ques = scpi_step(s_r.ques, ques_cond_in, clr_ques);
        s_nxt.oper = scpi_step(s_r.oper, oper_cond_in, clr_oper);

        // relies on ops_pending already covering earlier commands
        opc_fire = s_r.opc_armed && !ops_pending;
        if (opc_fire) begin
            s_nxt.opc_armed = 1'b0;
        end
        s_nxt.esr = (clr_esr ? 8'h00 : s_r.esr) | esr_set_in;
        s_nxt.esr[`SSR_ESR_OPC] = s_nxt.esr[`SSR_ESR_OPC]
                                  | opc_fire;

        // register reads answer one cycle after acceptance
        rdata = 16'h0000;
        case (cmd.sel)
            `SSR_SEL_QUES: rdata = scpi_read(s_r.ques, cmd.part);
            `SSR_SEL_OPER: rdata = scpi_read(s_r.oper, cmd.part);
            `SSR_SEL_ESR:  rdata = (cmd.part == `SSR_PART_ENA)
                                   ? {8'h00, s_r.ese}
                                   : {8'h00, s_r.esr};
            `SSR_SEL_SRE:  rdata = {8'h00, s_r.sre};
            `SSR_SEL_STB:  rdata = {8'h00, stb_raw};
            default:       rdata = 16'h0000;
        endcase
        s_nxt.rd.valid = 1'b0;
        s_nxt.rd.data  = s_r.rd.data;
        if (is_rd) begin
            s_nxt.rd.valid = 1'b1;
            s_nxt.rd.data  = rdata;
        end

        if (is_wr) begin
            case (cmd.sel)
                `SSR_SEL_QUES:
                    s_nxt.ques = scpi_write(s_nxt.ques, cmd.part,
                                            cmd.wdata);
                `SSR_SEL_OPER:
                    s_nxt.oper = scpi_write(s_nxt.oper, cmd.part,
                                            cmd.wdata);
                `SSR_SEL_ESR: begin
                    if (cmd.part == `SSR_PART_ENA) begin
                        s_nxt.ese = cmd.wdata[7:0];
                    end
                end
                `SSR_SEL_SRE: s_nxt.sre = cmd.wdata[7:0];
                default: s_nxt.sre = s_r.sre;
            endcase
        end

        // error queue: full drops the newest so history stays intact
        if (push) begin
            s_nxt.errq[s_r.wp] = err_code;
            s_nxt.wp = s_r.wp + 3'h1;
        end
        if (take && (cmd.op == ssr_pkg::SSR_OP_ERRQ)) begin
            s_nxt.rd.valid = 1'b1;
            s_nxt.rd.data  = pop ? s_r.errq[s_r.rp] : 16'h0000;
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + 3'h1;
        end
        case ({push, pop})
            2'b10:   s_nxt.cnt = s_r.cnt + 4'h1;
            2'b01:   s_nxt.cnt = s_r.cnt - 4'h1;
            default: s_nxt.cnt = s_r.cnt;
        endcase

        // synchronisation commands
        s_nxt.oq_push = 1'b0;
        case (s_r.sync)
            ssr_pkg::SSR_SY_IDLE: begin
                if (take && cmd.op == ssr_pkg::SSR_OP_OPC) begin
                    s_nxt.opc_armed = 1'b1;
                end
                if (take && cmd.op == ssr_pkg::SSR_OP_OPCQ) begin
                    s_nxt.sync = ssr_pkg::SSR_SY_OPCQ;
                end
                if (take && cmd.op == ssr_pkg::SSR_OP_WAI) begin
                    s_nxt.sync = ssr_pkg::SSR_SY_WAI;
                end
            end
            ssr_pkg::SSR_SY_WAI: begin
                if (!ops_pending) begin
                    s_nxt.sync = ssr_pkg::SSR_SY_IDLE;
                end
            end
            ssr_pkg::SSR_SY_OPCQ: begin
                if (!ops_pending) begin
                    s_nxt.oq_push = 1'b1;
                    s_nxt.sync    = ssr_pkg::SSR_SY_IDLE;
                end
            end
            default: s_nxt.sync = ssr_pkg::SSR_SY_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r           <= '0;
            s_r.ques.ptr  <= `SSR_PTR_RST;
            s_r.ques.ntr  <= `SSR_NTR_RST;
            s_r.ques.evt  <= `SSR_EVT_RST;
            s_r.ques.ena  <= `SSR_ENA_RST;
            s_r.oper.ptr  <= `SSR_PTR_RST;
            s_r.oper.ntr  <= `SSR_NTR_RST;
            s_r.oper.evt  <= `SSR_EVT_RST;
            s_r.oper.ena  <= `SSR_ENA_RST;
            s_r.sync      <= ssr_pkg::SSR_SY_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule : ssr_status
`default_nettype wire

// >>> tb/ssr_status_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ssr_status_checker (
    input wire logic               clk,
    input wire logic               reset,
    input wire ssr_pkg::ssr_cmd_t  cmd,
    input wire logic               cmd_valid,
    input wire logic               cmd_ready,
    input wire ssr_pkg::ssr_resp_t rd,
    input wire logic [14:0]        ques_cond_in,
    input wire logic [14:0]        oper_cond_in,
    input wire logic [7:0]         esr_set_in,
    input wire logic               ops_pending,
    input wire logic               err_push,
    input wire logic [15:0]        err_code,
    input wire logic               oq_not_empty,
    input wire logic               oq_push,
    input wire logic [15:0]        oq_data,
    input wire logic [7:0]         status_byte,
    input wire logic               srq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic tk = cmd_valid && cmd_ready;
    read_answer_a: assert property (tk && (cmd.op == ssr_pkg::SSR_OP_READ
        || cmd.op == ssr_pkg::SSR_OP_ERRQ) |=> rd.valid)
        else $error("read not answered next cycle");
    top_bit_a: assert property (tk && cmd.op == ssr_pkg::SSR_OP_READ
        |=> !rd.data[15])
        else $error("bit 15 of read data set");
    opcq_stall_a: assert property (
        tk && cmd.op == ssr_pkg::SSR_OP_OPCQ |=> !cmd_ready)
        else $error("query did not stall the port");
    wai_hold_a: assert property (!cmd_ready && ops_pending |=> !cmd_ready)
        else $error("port resumed while operations pending");
    push_gated_a: assert property (oq_push |-> !$past(ops_pending))
        else $error("response queued before completion");
    opcq_resp_a: assert property (oq_push |-> oq_data == 16'h0001)
        else $error("completion response not one");
    mav_rise_a: assert property (
        $rose(oq_not_empty) |-> ##[1:2] status_byte[4])
        else $error("message bit did not follow queue");
    srq_mss_a: assert property (srq |-> status_byte[6])
        else $error("service request without summary");
    cover property (oq_push);
    cover property (srq);
    cover property (rd.valid);
endmodule : ssr_status_checker
bind ssr_status ssr_status_checker u_chk (.clk(clk), .reset(reset),
    .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rd(rd),
    .ques_cond_in(ques_cond_in), .oper_cond_in(oper_cond_in),
    .esr_set_in(esr_set_in), .ops_pending(ops_pending),
    .err_push(err_push), .err_code(err_code), .oq_not_empty(oq_not_empty),
    .oq_push(oq_push), .oq_data(oq_data), .status_byte(status_byte),
    .srq(srq));
`default_nettype wire

// >>> tb/ssr_oq_model.sv
`timescale 1ns/1ns
`default_nettype none
module ssr_oq_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        oq_push,
    input  wire logic        oq_pop,
    input  wire logic [15:0] oq_data,
    output logic             oq_not_empty,
    output logic [15:0]      last
);
    logic [3:0] cnt_r;
    // controller side pops only when told, so the flag can be watched
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_r <= 4'h0;
            last  <= 16'h0000;
        end else begin
            cnt_r <= cnt_r + {3'h0, oq_push} - {3'h0, oq_pop && cnt_r != 4'h0};
            if (oq_push)
                last <= oq_data;
        end
    end
    assign oq_not_empty = (cnt_r != 4'h0);
endmodule : ssr_oq_model
`default_nettype wire

// >>> tb/scpi_status_event_reporting_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "ssr_regs.svh"
module scpi_status_event_reporting_test;
    logic               clk, reset, cmd_valid, cmd_ready, ops_pending;
    logic               err_push, oq_pop, oq_ne, oq_push, srq;
    ssr_pkg::ssr_cmd_t  cmd;
    ssr_pkg::ssr_resp_t rd;
    logic [14:0]        ques_c, oper_c;
    logic [15:0]        err_code, oq_data, oq_last;
    logic [7:0]         stb;
    logic [7:0]         esr_set;
    int                 n_fail, n_tests, n_srq, i, k;

    ssr_status DUT (.clk(clk), .reset(reset), .cmd(cmd),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rd(rd),
        .ques_cond_in(ques_c), .oper_cond_in(oper_c), .esr_set_in(esr_set),
        .ops_pending(ops_pending), .err_push(err_push), .err_code(err_code),
        .oq_not_empty(oq_ne), .oq_push(oq_push), .oq_data(oq_data),
        .status_byte(stb), .srq(srq));
    ssr_oq_model u_oq (.clk(clk), .reset(reset), .oq_push(oq_push),
        .oq_pop(oq_pop), .oq_data(oq_data), .oq_not_empty(oq_ne),
        .last(oq_last));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) if (srq === 1'b1) n_srq <= n_srq + 1;

    task tally_and_finish;
        if (n_fail == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    task chk(input string nm, input logic [15:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task go(input ssr_pkg::ssr_op_t o, input logic [2:0] s, p,
            input logic [15:0] w);
        @(posedge clk);
        cmd       <= '{op: o, sel: s, part: p, wdata: w};
        cmd_valid <= 1'b1;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
    endtask : go
    task wr(input logic [2:0] s, p, input logic [15:0] w);
        go(ssr_pkg::SSR_OP_WRITE, s, p, w);
    endtask : wr
    task rchk(input string nm, input logic q, input logic [2:0] s, p,
              input logic [15:0] e);
        go(q ? ssr_pkg::SSR_OP_ERRQ : ssr_pkg::SSR_OP_READ, s, p, 16'h0000);
        @(posedge clk);
        chk("rd_valid", 16'h0001, {15'h0000, rd.valid});
        chk(nm, e, rd.data);
    endtask : rchk
    // waits a bounded time for the next service request
    task wait_srq;
        for (i = 0; i < 20 && n_srq == k; i++) @(posedge clk);
        chk("srq_count", 16'(k + 1), 16'(n_srq));
    endtask : wait_srq
    task settle;
        repeat (3) @(posedge clk);
    endtask : settle
    // event set lands on the very edge that takes the clearing read
    task race(input logic [2:0] s, input logic [14:0] c,
              input logic [7:0] e);
        @(posedge clk);
        cmd       <= '{op: ssr_pkg::SSR_OP_READ, sel: s,
                       part: `SSR_PART_EVT, wdata: 16'h0000};
        cmd_valid <= 1'b1;
        ques_c    <= c;
        esr_set   <= e;
        @(posedge clk);
        chk("race_ready", 16'h0001, {15'h0000, cmd_ready});
        cmd_valid <= 1'b0;
        esr_set   <= 8'h00;
        @(posedge clk);
        chk("race_rd", 16'h0000, rd.data);
    endtask : race

    initial begin
        repeat (4000) @(posedge clk);
        n_fail++;
        tally_and_finish;
    end

    initial begin
        {cmd, cmd_valid, ops_pending, err_push, oq_pop} = '0;
        {ques_c, oper_c, err_code, esr_set} = '0;
        reset = 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        for (k = 0; k < 2; k++) begin
            rchk("ptr_rst", 0, 3'(k), `SSR_PART_PTR, 16'h7fff);
            rchk("ntr_rst", 0, 3'(k), `SSR_PART_NTR, 16'h0000);
            rchk("evt_rst", 0, 3'(k), `SSR_PART_EVT, 16'h0000);
            rchk("ena_rst", 0, 3'(k), `SSR_PART_ENA, 16'h0000);
            rchk("cond_rst", 0, 3'(k), `SSR_PART_COND, 16'h0000);
        end
        wr(`SSR_SEL_QUES, `SSR_PART_PTR, 16'hffff);
        rchk("ptr_wr", 0, `SSR_SEL_QUES, `SSR_PART_PTR, 16'h7fff);
        wr(`SSR_SEL_QUES, `SSR_PART_PTR, 16'h0001);
        wr(`SSR_SEL_QUES, `SSR_PART_NTR, 16'h0002);
        wr(`SSR_SEL_QUES, `SSR_PART_ENA, 16'h0002);
        wr(`SSR_SEL_QUES, `SSR_PART_COND, 16'h0fff);
        @(posedge clk) ques_c <= 15'h0003;
        settle;
        rchk("cond", 0, `SSR_SEL_QUES, `SSR_PART_COND, 16'h0003);
        rchk("cond2", 0, `SSR_SEL_QUES, `SSR_PART_COND, 16'h0003);
        rchk("evt_rise", 0, `SSR_SEL_QUES, `SSR_PART_EVT, 16'h0001);
        rchk("evt_clr", 0, `SSR_SEL_QUES, `SSR_PART_EVT, 16'h0000);
        @(posedge clk) ques_c <= 15'h0000;
        settle;
        chk("ques_sum", 16'h0001, {15'h0000, stb[3]});
        rchk("evt_fall", 0, `SSR_SEL_QUES, `SSR_PART_EVT, 16'h0002);
        settle;
        chk("ques_sum_clr", 16'h0000, {15'h0000, stb[3]});
        wr(`SSR_SEL_OPER, `SSR_PART_ENA, 16'h4000);
        @(posedge clk) oper_c <= 15'h4000;
        settle;
        chk("oper_sum", 16'h0001, {15'h0000, stb[7]});
        rchk("oper_evt", 0, `SSR_SEL_OPER, `SSR_PART_EVT, 16'h4000);
        wr(`SSR_SEL_ESR, `SSR_PART_ENA, 16'h0001);
        wr(`SSR_SEL_SRE, 3'h0, 16'h0020);
        @(posedge clk) ops_pending <= 1'b1;
        go(ssr_pkg::SSR_OP_OPC, 3'h0, 3'h0, 16'h0000);
        k = n_srq;
        settle;
        chk("srq_early", 16'(k), 16'(n_srq));
        ops_pending <= 1'b0;
        wait_srq;
        chk("esb", 16'h0001, {15'h0000, stb[5]});
        rchk("esr_opc", 0, `SSR_SEL_ESR, `SSR_PART_EVT, 16'h0001);
        rchk("esr_clr", 0, `SSR_SEL_ESR, `SSR_PART_EVT, 16'h0000);
        go(ssr_pkg::SSR_OP_OPC, 3'h0, 3'h0, 16'h0000);
        rchk("esr_poll", 0, `SSR_SEL_ESR, `SSR_PART_EVT, 16'h0001);
        race(`SSR_SEL_ESR, 15'h0000, 8'h04);
        rchk("esr_kept", 0, `SSR_SEL_ESR, `SSR_PART_EVT, 16'h0004);
        race(`SSR_SEL_QUES, 15'h0001, 8'h00);
        rchk("evt_kept", 0, `SSR_SEL_QUES, `SSR_PART_EVT, 16'h0001);
        wr(`SSR_SEL_SRE, 3'h0, 16'h0010);
        @(posedge clk) ops_pending <= 1'b1;
        go(ssr_pkg::SSR_OP_OPCQ, 3'h0, 3'h0, 16'h0000);
        settle;
        chk("opcq_wait", 16'h0000, {15'h0000, cmd_ready});
        chk("oq_early", 16'h0000, {15'h0000, oq_ne});
        k = n_srq;
        ops_pending <= 1'b0;
        wait_srq;
        chk("oq_resp", 16'h0001, oq_last);
        chk("mav", 16'h0001, {15'h0000, stb[4]});
        chk("mss", 16'h0001, {15'h0000, stb[6]});
        @(posedge clk) oq_pop <= 1'b1;
        @(posedge clk) oq_pop <= 1'b0;
        settle;
        chk("mav_clr", 16'h0000, {15'h0000, stb[4]});
        @(posedge clk) ops_pending <= 1'b1;
        go(ssr_pkg::SSR_OP_WAI, 3'h0, 3'h0, 16'h0000);
        settle;
        chk("wai_hold", 16'h0000, {15'h0000, cmd_ready});
        ops_pending <= 1'b0;
        rchk("after_wai", 0, `SSR_SEL_QUES, `SSR_PART_PTR, 16'h0001);
        // back-to-back pushes, read back oldest first
        for (k = 1; k < 4; k++) begin
            @(posedge clk);
            err_push <= 1'b1;
            err_code <= 16'(k * 17);
        end
        @(posedge clk) err_push <= 1'b0;
        settle;
        chk("errq_flag", 16'h0001, {15'h0000, stb[2]});
        rchk("stb_rd", 0, `SSR_SEL_STB, 3'h0, 16'h0004);
        rchk("sre_rd", 0, `SSR_SEL_SRE, 3'h0, 16'h0010);
        rchk("ese_rd", 0, `SSR_SEL_ESR, `SSR_PART_ENA, 16'h0001);
        for (k = 1; k < 4; k++)
            rchk("errq", 1, 3'h0, 3'h0, 16'(k * 17));
        rchk("errq_empty", 1, 3'h0, 3'h0, 16'h0000);
        tally_and_finish;
    end
endmodule : scpi_status_event_reporting_test
`default_nettype wire
